// *** src/mpes_port_events.sv ***
// Per-port interrupt enable, interrupt status, transmit and receive status.
// Assumes the datapath pulses come from logic on clk, and the CPU port
// presents one-clock read or write strobes with a stable address.
`timescale 1ns/1ps
`include "mpes_cfg.svh"
// What this block does
// - Enable bits 6..0 permit stop, overflow, link, tx error, tx ok, rx event, rx ok.
// - Reading transmit status clears all bits except the packet count.
// - Transmit error bits set only when the error mode stops on that error.
// - Bits 7:6 count FIFO packets, up on first byte, down after send, max 2.
// - Transmit bit 2 marks sixteen failed attempts from consecutive collisions.
// - Transmit bit 1 marks a collision after 64 bytes were sent.
// - Transmit bit 0 marks FIFO running empty after 64 bytes were sent.
// - Reading receive status clears every bit.
// - Receive bits set only when filtering passes packets with that event.
// - Several errors not all passed by filtering leave receive status clear.
// - The receive status byte follows the last data byte into the FIFO.
// - Receive bit 7 marks a flow-control frame; bit 6 reads zero.
// - Receive bit 5 marks symbol error in symbol mode or MII error otherwise.
// - Receive bit 4 marks a frame over the maximum size.
// - Receive bit 3 marks a frame shorter than 64 bytes.
// - Receive bit 2 marks CRC mismatch with framing error.
// - Receive bit 1 marks CRC mismatch without framing error.
// - Receive bit 0 marks receive FIFO lacking space.
// - An event sets its interrupt status bit only when enabled.
// - Reading interrupt status clears all but the two summaries.
// - Transmit error summary is the OR of transmit error bits.
// - Receive event summary is the OR of receive status after full reception.
module mpes_port_events import mpes_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rd_valid,
  input wire logic [2:0] transmit_error_mode,
  input wire logic [7:0] receive_filter_mode,
  input wire logic symbol_interface_mode,
  input wire mpes_tx_event_type tx_event,
  input wire mpes_rx_frame_type rx_frame,
  input wire mpes_port_event_type port_event,
  output logic rx_status_fifo_wr,
  output logic [7:0] rx_status_fifo_data,
  output logic irq
);
  logic [7:0] int_enable_reg;
  logic [7:0] int_status_reg;
  logic [7:0] int_status_next;
  logic [2:0] tx_err_reg;
  logic [2:0] tx_err_next;
  logic [1:0] tx_fifo_packet_count_reg;
  logic [7:0] rx_status_reg;
  logic [7:0] rx_status_next;
  logic [7:0] rx_events;
  logic [7:0] rx_byte;
  logic rx_ok_event;
  logic rd_int;
  logic rd_tx;
  logic rd_rx;
  mpes_access_type access;

  // Address decode of the CPU strobes
  always_comb begin
    access = MPES_ACC_IDLE;
    if (cpu_rd) begin
      access = MPES_ACC_READ;
    end else if (cpu_wr) begin
      access = MPES_ACC_WRITE;
    end
  end
  assign rd_int = (access == MPES_ACC_READ) && (cpu_addr == `MPES_OFS_INT_STATUS);
  assign rd_tx = (access == MPES_ACC_READ) && (cpu_addr == `MPES_OFS_TX_STATUS);
  assign rd_rx = (access == MPES_ACC_READ) && (cpu_addr == `MPES_OFS_RX_STATUS);

  // Enable register; reserved bit 7 is never stored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_enable_reg <= `MPES_RESET_BYTE;
    end else if (access == MPES_ACC_WRITE && cpu_addr == `MPES_OFS_INT_ENABLE) begin
      int_enable_reg <= cpu_wdata & `MPES_IRQ_USED;
    end
  end

  // Transmit error causes; a new error in the read cycle survives the clear
  always_comb begin
    tx_err_next = rd_tx ? 3'h0 : tx_err_reg;
    if (transmit_error_mode[`MPES_TX_XCOL] && tx_event.excessive_collision) begin
      tx_err_next[`MPES_TX_XCOL] = 1'b1;
    end
    if (transmit_error_mode[`MPES_TX_LCOL] && tx_event.late_collision) begin
      tx_err_next[`MPES_TX_LCOL] = 1'b1;
    end
    if (transmit_error_mode[`MPES_TX_UNDERFLOW] && tx_event.tx_fifo_underflow) begin
      tx_err_next[`MPES_TX_UNDERFLOW] = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_err_reg <= 3'h0;
    end else begin
      tx_err_reg <= tx_err_next;
    end
  end

  // Packet count: load and send in one cycle cancel; saturates so a
  // misbehaving datapath cannot wrap the two-bit field
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tx_fifo_packet_count_reg <= 2'h0;
    end else if (tx_event.pkt_first_byte && !tx_event.pkt_sent) begin
      if (tx_fifo_packet_count_reg != `MPES_TX_CNT_MAX) begin
        tx_fifo_packet_count_reg <= tx_fifo_packet_count_reg + 2'h1;
      end
    end else if (tx_event.pkt_sent && !tx_event.pkt_first_byte) begin
      if (tx_fifo_packet_count_reg != 2'h0) begin
        tx_fifo_packet_count_reg <= tx_fifo_packet_count_reg - 2'h1;
      end
    end
  end

  // Receive event vector of the frame just ended
  always_comb begin
    rx_events = 8'h00;
    rx_events[`MPES_RX_FLOW_CTRL] = rx_frame.flow_control_frame_seen;
    rx_events[`MPES_RX_PHY_ERR] = symbol_interface_mode ? rx_frame.symbol_error
                                                        : rx_frame.mii_rx_error;
    rx_events[`MPES_RX_LONG] = rx_frame.too_long;
    rx_events[`MPES_RX_SHORT] = rx_frame.too_short;
    rx_events[`MPES_RX_ALIGN] = rx_frame.crc_bad && rx_frame.framing_bad;
    rx_events[`MPES_RX_CRC] = rx_frame.crc_bad && !rx_frame.framing_bad;
    rx_events[`MPES_RX_OVERFLOW] = rx_frame.rx_fifo_overflow;
  end
  // Only report when filtering passes every event present, else nothing
  assign rx_byte = ((rx_events & ~receive_filter_mode) == 8'h00)
                   ? (rx_events & `MPES_RX_USED) : 8'h00;
  assign rx_ok_event = rx_frame.frame_end && (rx_events == 8'h00);

  // Receive status; a frame ending in the read cycle is not lost
  always_comb begin
    rx_status_next = rd_rx ? 8'h00 : rx_status_reg;
    if (rx_frame.frame_end) begin
      rx_status_next = rx_status_next | rx_byte;
    end
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_status_reg <= `MPES_RESET_BYTE;
    end else begin
      rx_status_reg <= rx_status_next;
    end
  end

  // Status byte trails the last data byte into the receive FIFO
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_status_fifo_wr <= 1'b0;
      rx_status_fifo_data <= `MPES_RESET_BYTE;
    end else begin
      rx_status_fifo_wr <= rx_frame.frame_end;
      if (rx_frame.frame_end) begin
        rx_status_fifo_data <= rx_byte;
      end
    end
  end

  // Interrupt status: sticky bits gated by enables, set wins over read clear;
  // summaries follow their status registers instead of the read
  always_comb begin
    int_status_next = rd_int ? 8'h00 : int_status_reg;
    if (port_event.port_stop && int_enable_reg[`MPES_IRQ_STOP]) begin
      int_status_next[`MPES_IRQ_STOP] = 1'b1;
    end
    if (port_event.counter_overflow && int_enable_reg[`MPES_IRQ_OVFC]) begin
      int_status_next[`MPES_IRQ_OVFC] = 1'b1;
    end
    if (port_event.link_change && int_enable_reg[`MPES_IRQ_LINK]) begin
      int_status_next[`MPES_IRQ_LINK] = 1'b1;
    end
    if (tx_event.tx_ok && int_enable_reg[`MPES_IRQ_TXOK]) begin
      int_status_next[`MPES_IRQ_TXOK] = 1'b1;
    end
    if (rx_ok_event && int_enable_reg[`MPES_IRQ_RXOK]) begin
      int_status_next[`MPES_IRQ_RXOK] = 1'b1;
    end
    int_status_next[`MPES_IRQ_TX_ERR] = int_enable_reg[`MPES_IRQ_TX_ERR]
                                        && (|tx_err_next);
    int_status_next[`MPES_IRQ_RX_EVENT] = int_enable_reg[`MPES_IRQ_RX_EVENT]
                                          && (|rx_status_next);
  end
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_status_reg <= `MPES_RESET_BYTE;
      irq <= 1'b0;
    end else begin
      int_status_reg <= int_status_next;
      irq <= |int_status_next;
    end
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cpu_rdata <= `MPES_RESET_BYTE;
      cpu_rd_valid <= 1'b0;
    end else begin
      cpu_rd_valid <= (access == MPES_ACC_READ);
      if (access == MPES_ACC_READ) begin
        case (cpu_addr)
          `MPES_OFS_INT_STATUS: cpu_rdata <= int_status_reg;
          `MPES_OFS_INT_ENABLE: cpu_rdata <= int_enable_reg;
          `MPES_OFS_TX_STATUS: cpu_rdata <= {tx_fifo_packet_count_reg, 3'h0, tx_err_reg};
          `MPES_OFS_RX_STATUS: cpu_rdata <= rx_status_reg;
          default: cpu_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Checks next to the logic
  enable_reserved_a: assert property (@(posedge clk) disable iff (!reset_n)
    !int_enable_reg[7]) else $error("enable bit 7 stored");
  tx_read_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_tx && !tx_event.excessive_collision && !tx_event.late_collision
    && !tx_event.tx_fifo_underflow |=> tx_err_reg == 3'h0)
    else $error("tx status not cleared by read");
  tx_mode_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_event.late_collision && !transmit_error_mode[`MPES_TX_LCOL]
    && !tx_err_reg[`MPES_TX_LCOL]
    |=> !tx_err_reg[`MPES_TX_LCOL]) else $error("late collision set while masked");
  xcol_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_event.excessive_collision && transmit_error_mode[`MPES_TX_XCOL]
    |=> tx_err_reg[`MPES_TX_XCOL]) else $error("excessive collision missed");
  count_limit_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_fifo_packet_count_reg <= `MPES_TX_CNT_MAX) else $error("packet count over 2");
  count_up_a: assert property (@(posedge clk) disable iff (!reset_n)
    tx_event.pkt_first_byte && !tx_event.pkt_sent && tx_fifo_packet_count_reg == 2'h0
    |=> tx_fifo_packet_count_reg == 2'h1) else $error("packet count not raised");
  rx_read_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_rx && !rx_frame.frame_end |=> rx_status_reg == 8'h00)
    else $error("rx status not cleared by read");
  rx_filter_all_a: assert property (@(posedge clk) disable iff (!reset_n)
    rx_frame.frame_end && rx_frame.crc_bad && !rx_frame.framing_bad
    && rx_frame.too_short && !receive_filter_mode[`MPES_RX_SHORT]
    |=> rx_status_fifo_data == 8'h00) else $error("partly passed errors reported");
  rx_fifo_byte_a: assert property (@(posedge clk) disable iff (!reset_n)
    rx_frame.frame_end |=> rx_status_fifo_wr && rx_status_fifo_data == $past(rx_byte))
    else $error("status byte not appended");
  int_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(int_status_reg[`MPES_IRQ_LINK]) |-> $past(int_enable_reg[`MPES_IRQ_LINK]))
    else $error("link change set while disabled");
  summary_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
    rd_int && !rd_tx && (|tx_err_reg) && int_enable_reg[`MPES_IRQ_TX_ERR]
    |=> int_status_reg[`MPES_IRQ_TX_ERR]) else $error("tx summary cleared by read");
  rx_summary_a: assert property (@(posedge clk) disable iff (!reset_n)
    int_status_reg[`MPES_IRQ_RX_EVENT] |-> (|rx_status_reg))
    else $error("rx summary without status");
  irq_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
    irq == (|int_status_reg)) else $error("irq does not follow status");
endmodule : mpes_port_events

// *** src/mpes_cfg.svh ***
// Constants of the per-port event and status block.
// Assumes inclusion by bare name from the package and the module.
`ifndef MPES_CFG_SVH
`define MPES_CFG_SVH
// Register offsets on the CPU register port
`define MPES_OFS_INT_STATUS 8'h01
`define MPES_OFS_INT_ENABLE 8'h02
`define MPES_OFS_TX_STATUS 8'h03
`define MPES_OFS_RX_STATUS 8'h04
// Interrupt status and enable bit positions
`define MPES_IRQ_STOP 6
`define MPES_IRQ_OVFC 5
`define MPES_IRQ_LINK 4
`define MPES_IRQ_TX_ERR 3
`define MPES_IRQ_TXOK 2
`define MPES_IRQ_RX_EVENT 1
`define MPES_IRQ_RXOK 0
`define MPES_IRQ_USED 8'h7F
// Transmit status fields
`define MPES_TX_CNT_HI 7
`define MPES_TX_CNT_LO 6
`define MPES_TX_CNT_MAX 2'h2
`define MPES_TX_XCOL 2
`define MPES_TX_LCOL 1
`define MPES_TX_UNDERFLOW 0
`define MPES_TX_ERR_MASK 8'h07
// Receive status bits
`define MPES_RX_FLOW_CTRL 7
`define MPES_RX_PHY_ERR 5
`define MPES_RX_LONG 4
`define MPES_RX_SHORT 3
`define MPES_RX_ALIGN 2
`define MPES_RX_CRC 1
`define MPES_RX_OVERFLOW 0
`define MPES_RX_USED 8'hBF
`define MPES_RESET_BYTE 8'h00
`endif

// *** src/mpes_pkg.sv ***
// Types shared by the per-port event and status block.
// Assumes mpes_cfg.svh is on the include path.
`include "mpes_cfg.svh"
package mpes_pkg;
  // Transmit path event pulses, one clock each
  typedef struct packed {
    logic excessive_collision;
    logic late_collision;
    logic tx_fifo_underflow;
    logic tx_ok;
    logic pkt_first_byte;
    logic pkt_sent;
  } mpes_tx_event_type;
  // Receive frame conditions, valid with frame_end
  typedef struct packed {
    logic frame_end;
    logic flow_control_frame_seen;
    logic symbol_error;
    logic mii_rx_error;
    logic too_long;
    logic too_short;
    logic crc_bad;
    logic framing_bad;
    logic rx_fifo_overflow;
  } mpes_rx_frame_type;
  // Other port events, one-clock pulses
  typedef struct packed {
    logic port_stop;
    logic counter_overflow;
    logic link_change;
  } mpes_port_event_type;
  typedef enum logic [1:0] {
    MPES_ACC_IDLE = 2'b00,
    MPES_ACC_READ = 2'b01,
    MPES_ACC_WRITE = 2'b10
  } mpes_access_type;
endpackage : mpes_pkg

// *** test/mpes_tb_top.sv ***
// Self-checking bench for the per-port event and status block.
// Assumes mpes_pkg and mpes_port_events are compiled first; no far-side model.
`timescale 1ns/1ps
module mac_port_event_status_tb_top import mpes_pkg::*;;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] cpu_addr = 8'h00;
  logic cpu_rd = 1'b0;
  logic cpu_wr = 1'b0;
  logic [7:0] cpu_wdata = 8'h00;
  logic [7:0] cpu_rdata;
  logic cpu_rd_valid;
  logic [2:0] transmit_error_mode = 3'h0;
  logic [7:0] receive_filter_mode = 8'h00;
  logic symbol_interface_mode = 1'b0;
  mpes_tx_event_type tx_event = '0;
  mpes_rx_frame_type rx_frame = '0;
  mpes_port_event_type port_event = '0;
  logic rx_status_fifo_wr;
  logic [7:0] rx_status_fifo_data;
  logic irq;
  logic [7:0] rd_q[$];
  logic [7:0] fifo_q[$];
  logic [7:0] rx_acc = 8'h00;
  logic [31:0] seed = 32'h873C;
  int n_errors = 0;
  int total_checks = 0;
  int i;
  always #20 clk = ~clk;
  mpes_port_events mpes_port_events_i (.clk(clk), .reset_n(reset_n), .cpu_addr(cpu_addr),
    .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_rd_valid(cpu_rd_valid), .transmit_error_mode(transmit_error_mode),
    .receive_filter_mode(receive_filter_mode), .symbol_interface_mode(symbol_interface_mode),
    .tx_event(tx_event), .rx_frame(rx_frame), .port_event(port_event),
    .rx_status_fifo_wr(rx_status_fifo_wr), .rx_status_fifo_data(rx_status_fifo_data),
    .irq(irq));
  // One compare for every byte-sized result; an unknown never matches
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Receive FIFO status bytes and the interrupt line have compares of their own
  task automatic chk_fifo(input logic [7:0] exp);
    chk(rx_status_fifo_data, exp);
  endtask : chk_fifo
  task automatic chk_irq(input logic exp);
    chk({7'h00, irq}, {7'h00, exp});
  endtask : chk_irq
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  function automatic logic [31:0] rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // Strobes last exactly one clock, so each call is one access
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_wr = 1'b1;
    cpu_addr = a;
    cpu_wdata = d;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    cpu_rd = 1'b1;
    cpu_addr = a;
    rd_q.push_back(exp);
    @(negedge clk);
    cpu_rd = 1'b0;
  endtask : rd
  task automatic ev(input mpes_tx_event_type t, input mpes_port_event_type p);
    @(negedge clk);
    tx_event = t;
    port_event = p;
    @(negedge clk);
    tx_event = '0;
    port_event = '0;
  endtask : ev
  // Expected byte is built from the flags and the filter as they stand now
  task automatic frame(input logic [7:0] f);
    logic [7:0] e;
    logic [7:0] b;
    @(negedge clk);
    rx_frame = {1'b1, f};
    e = {f[7], 1'b0, symbol_interface_mode ? f[6] : f[5], f[4], f[3], f[2] & f[1],
      f[2] & ~f[1], f[0]};
    b = ((e & ~receive_filter_mode) == 8'h00) ? e : 8'h00;
    fifo_q.push_back(b);
    rx_acc = rx_acc | b;
    @(negedge clk);
    rx_frame = '0;
  endtask : frame
  // Results are taken off the note queues as the registered outputs show them
  always @(negedge clk) begin
    if (cpu_rd_valid === 1'b1) begin
      if (rd_q.size() == 0) chk(8'hEE, 8'h00);
      else chk(cpu_rdata, rd_q.pop_front());
    end
    if (rx_status_fifo_wr === 1'b1) begin
      if (fifo_q.size() == 0) chk(8'hEE, 8'h00);
      else chk_fifo(fifo_q.pop_front());
    end
  end
  // Watchdog at 10000 cycles, well past the roughly 180 cycles the sequence needs
  initial begin
    #400000;
    n_errors++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    for (i = 1; i < 6; i++) rd(i[7:0], 8'h00);
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h7F);
    ev(6'b000100, 3'b111);
    @(negedge clk);
    chk_irq(1'b1);
    rd(8'h01, 8'h74);
    rd(8'h01, 8'h00);
    @(negedge clk);
    chk_irq(1'b0);
    wr(8'h02, 8'h00);
    ev(6'b000100, 3'b111);
    rd(8'h01, 8'h00);
    wr(8'h02, 8'h7F);
    transmit_error_mode = 3'h7;
    ev(6'b111000, 3'b000);
    rd(8'h01, 8'h08);
    rd(8'h01, 8'h08);
    rd(8'h03, 8'h07);
    rd(8'h03, 8'h00);
    rd(8'h01, 8'h00);
    transmit_error_mode = 3'h0;
    ev(6'b111000, 3'b000);
    rd(8'h03, 8'h00);
    for (i = 0; i < 3; i++) ev(6'b000010, 3'b000);
    rd(8'h03, 8'h80);
    rd(8'h03, 8'h80);
    ev(6'b000001, 3'b000);
    rd(8'h03, 8'h40);
    wr(8'h02, 8'h00);
    for (i = 0; i < 40; i++) begin
      receive_filter_mode = 8'(rnd() | rnd());
      symbol_interface_mode = 1'(rnd());
      frame(8'(rnd() & rnd()));
      if (i % 8 == 7) begin
        rd(8'h04, rx_acc);
        rx_acc = 8'h00;
      end
    end
    rd(8'h04, 8'h00);
    wr(8'h02, 8'h03);
    receive_filter_mode = 8'h02;
    frame(8'h0C);
    frame(8'h00);
    rd(8'h01, 8'h01);
    frame(8'h04);
    rd(8'h01, 8'h02);
    rd(8'h04, 8'h02);
    rd(8'h01, 8'h00);
    repeat (4) @(negedge clk);
    chk(8'(rd_q.size() + fifo_q.size()), 8'h00);
    conclude();
  end
endmodule : mac_port_event_status_tb_top
